/* verilog/crank_cond_pkg.sv */
// Purpose: Shared constants and types for the crank sensor conditioner register bank.
// Assumes: Register frames arrive already decoded from the serial port.
// Notes:   Offset B is shared by configuration and status, offset D by configuration and control; offset C is configuration only.

package crank_cond_pkg;

  // ==========================================================================
  // Register spaces and offsets
  // ==========================================================================
  typedef enum logic [2:0] {
    SPACE_CONFIG  = 3'b001,
    SPACE_CONTROL = 3'b010,
    SPACE_STATUS  = 3'b100
  } reg_space_t;

  localparam logic [3:0] ADDR_RUN_STATUS = 4'hB;
  localparam logic [3:0] ADDR_AUTO       = 4'hC;
  localparam logic [3:0] ADDR_MISC_CRANK = 4'hD;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] RUN_RESET    = 8'h53;
  localparam logic [7:0] AUTO_RESET   = 8'h21;
  localparam logic [7:0] MISC_RESET   = 8'h00;
  localparam logic [7:0] CRANK_RESET  = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [3:0] PEAK_RESET   = 4'h0;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int THR_MSB        = 7;
  localparam int THR_LSB        = 4;
  localparam int BLANK_MSB      = 3;
  localparam int BLANK_LSB      = 0;
  localparam int MANT_MSB       = 7;
  localparam int MANT_LSB       = 5;
  localparam int EXP_MSB        = 3;
  localparam int EXP_LSB        = 0;
  localparam int MISC_AUTO      = 7;
  localparam int MISC_DISABLE   = 6;
  localparam int MISC_LOWPULSE  = 4;
  localparam int MISC_DEGLITCH  = 3;
  localparam int MISC_SINGLE    = 2;
  localparam int MISC_SWAP      = 1;
  localparam int MISC_REFDIS    = 0;
  localparam int STAT_PEAK_MSB  = 7;
  localparam int STAT_PEAK_LSB  = 4;
  localparam int STAT_CLAMP_POS = 2;
  localparam int STAT_CLAMP_NEG = 1;
  localparam int STAT_OVERTEMP  = 0;

  // ==========================================================================
  // Automatic threshold decay
  // ==========================================================================
  localparam logic [3:0] THRESH_MAX  = 4'hF;
  localparam logic [4:0] MANT_BIAS   = 5'h10;
  localparam int         DECAY_CNT_W = 20;

endpackage

/* verilog/threshold_decay.sv */
// Purpose: Automatic comparator threshold decay after each zero crossing.
// Assumes: zero_cross is a one-cycle pulse synchronous to clk_sys.
// Notes:   One threshold code step per interval of (16 + mantissa) << exponent cycles.

`timescale 1ns/10ps

module threshold_decay (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       auto_active,
  input  wire logic       zero_cross,
  input  wire logic [3:0] target,
  input  wire logic [2:0] mantissa,
  input  wire logic [3:0] exponent,
  output logic      [3:0] threshold
);

  // ==========================================================================
  // State and interval
  // ==========================================================================
  typedef enum logic [1:0] {
    DECAY_IDLE = 2'b01,
    DECAY_RUN  = 2'b10
  } decay_state_t;

  decay_state_t                                state;
  logic         [crank_cond_pkg::DECAY_CNT_W-1:0] count;
  logic         [crank_cond_pkg::DECAY_CNT_W-1:0] interval;

  // The interval follows register writes at once, so a retune takes hold mid-decay.
  assign interval = DECAY_CNT_W_SHIFT({2'b00, mantissa}, exponent);  // see RULE3

  function automatic logic [crank_cond_pkg::DECAY_CNT_W-1:0] DECAY_CNT_W_SHIFT(
    input logic [4:0] mant,
    input logic [3:0] expo
  );
    logic [crank_cond_pkg::DECAY_CNT_W-1:0] base;
    base = {15'h0000, mant + crank_cond_pkg::MANT_BIAS};
    return base << expo;
  endfunction

  // ==========================================================================
  // Decay sequence
  // ==========================================================================
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state     <= DECAY_IDLE;
      count     <= '0;
      threshold <= 4'h0;
    end else if (!auto_active) begin
      state     <= DECAY_IDLE;
      count     <= '0;
      threshold <= target;
    end else if (zero_cross) begin
      state     <= DECAY_RUN;  // see RULE17
      count     <= '0;
      threshold <= crank_cond_pkg::THRESH_MAX;
    end else begin
      unique case (state)
        DECAY_IDLE: begin
          threshold <= target;
        end
        DECAY_RUN: begin
          if (threshold <= target) begin
            state     <= DECAY_IDLE;
            threshold <= target;
          end else if (count == interval - 1'b1) begin
            count     <= '0;
            threshold <= threshold - 4'h1;  // see RULE17
          end else begin
            count <= count + 1'b1;
          end
        end
      endcase
    end
  end

endmodule

/* verilog/crank_sensor_conditioner_regs.sv */
// Purpose: Register bank for the crank sensor conditioner and the K-line relay.
// Assumes: Frames are checked elsewhere; frame_valid marks one accepted 16-bit frame.
// Notes:   Analog parts sit outside; this block only steers and reports them.
//
// Contract
// RULE1: Running register holds threshold in bits 7-4, blanking in bits 3-0.
// RULE2: Cranking register holds threshold 7-4, blanking 3-0, resets to zero.
// RULE3: Automatic register holds mantissa 7-5 and exponent 3-0 for decay timing.
// RULE4: Misc bit 7 picks manual (0, default) or automatic cranking threshold.
// RULE5: Misc bit 6 set disables the conditioner; clear keeps it enabled.
// RULE6: Misc bit 4 picks high-pulse (0) or low-pulse (1) timing.
// RULE7: Misc bit 3 set enables the extra edge deglitch filter.
// RULE8: Misc bit 2 picks differential (0) or single-ended (1) input.
// RULE9: Misc bit 1 set swaps positive and negative sensor inputs.
// RULE10: Misc bit 0 set disconnects the internal common-mode reference.
// RULE11: Status bits 7-4 report the latest positive peak magnitude code.
// RULE12: Status bit 2 reads 1 once the positive clamp is reached.
// RULE13: Status bit 1 reads 1 once the negative clamp is reached.
// RULE14: Status bit 0 flags a K-line overtemperature fault.
// RULE15: Host transmit drives the K-line; K-line level returns to the host.
// RULE16: Peak keeps last value; zero only after reset or serial reset.
// RULE17: Automatic mode forces maximum threshold at zero crossing, then decays.
// RULE18: Host only clears status bits unless self-test write is enabled.
// RULE19: Register updates happen only on a complete accepted frame.

`timescale 1ns/10ps

module crank_sensor_conditioner_regs (
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  input  wire logic                       frame_valid,
  input  wire logic                       frame_write,
  input  wire crank_cond_pkg::reg_space_t frame_space,
  input  wire logic [3:0]                 frame_addr,
  input  wire logic [7:0]                 frame_wdata,
  output logic      [7:0]                 frame_rdata,
  output logic                            frame_error,
  input  wire logic                       serial_reset_cmd,
  input  wire logic                       self_test_write_enable,
  input  wire logic                       engine_cranking,
  input  wire logic                       zero_cross,
  input  wire logic                       peak_valid,
  input  wire logic [3:0]                 peak_code,
  input  wire logic                       clamp_pos_hit,
  input  wire logic                       clamp_neg_hit,
  input  wire logic                       kline_overtemp,
  input  wire logic                       kline_tx_from_host,
  input  wire logic                       kline_in,
  output logic                            kline_out,
  output logic                            kline_oe_n,
  output logic                            kline_rx_to_host,
  output logic      [3:0]                 thresh_sel,
  output logic      [3:0]                 blank_sel,
  output logic                            conditioner_enable,
  output logic                            pulse_low_select,
  output logic                            deglitch_enable,
  output logic                            single_ended_select,
  output logic                            inputs_swapped,
  output logic                            common_ref_disconnect
);

  // ==========================================================================
  // Storage and decode
  // ==========================================================================
  logic [7:0] running;
  logic [7:0] auto_par;
  logic [7:0] misc;
  logic [7:0] cranking;
  logic [3:0] peak;
  logic       clamp_pos;
  logic       clamp_neg;
  logic       overtemp;
  logic [3:0] decay_thr;
  logic       wr_run;
  logic       wr_auto;
  logic       wr_misc;
  logic       wr_crank;
  logic       wr_status;
  logic [7:0] status_word;

  function automatic logic hit(
    input crank_cond_pkg::reg_space_t space,
    input logic [3:0]                 addr,
    input crank_cond_pkg::reg_space_t want_space,
    input logic [3:0]                 want_addr
  );
    return (space == want_space) && (addr == want_addr);
  endfunction

  // Writes only count for a frame that was accepted whole.
  assign wr_run    = frame_valid && frame_write &&
                     hit(frame_space, frame_addr, crank_cond_pkg::SPACE_CONFIG,
                         crank_cond_pkg::ADDR_RUN_STATUS);  // see RULE19
  assign wr_auto   = frame_valid && frame_write &&
                     hit(frame_space, frame_addr, crank_cond_pkg::SPACE_CONFIG,
                         crank_cond_pkg::ADDR_AUTO);
  assign wr_misc   = frame_valid && frame_write &&
                     hit(frame_space, frame_addr, crank_cond_pkg::SPACE_CONFIG,
                         crank_cond_pkg::ADDR_MISC_CRANK);
  assign wr_crank  = frame_valid && frame_write &&
                     hit(frame_space, frame_addr, crank_cond_pkg::SPACE_CONTROL,
                         crank_cond_pkg::ADDR_MISC_CRANK);
  assign wr_status = frame_valid && frame_write &&
                     hit(frame_space, frame_addr, crank_cond_pkg::SPACE_STATUS,
                         crank_cond_pkg::ADDR_RUN_STATUS);

  assign status_word = {peak, 1'b0, clamp_pos, clamp_neg, overtemp};

  // ==========================================================================
  // Configuration and control registers
  // ==========================================================================
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      running  <= crank_cond_pkg::RUN_RESET;
      auto_par <= crank_cond_pkg::AUTO_RESET;
      misc     <= crank_cond_pkg::MISC_RESET;
      cranking <= crank_cond_pkg::CRANK_RESET;  // see RULE2
    end else begin
      if (wr_run) begin
        running <= frame_wdata;  // see RULE1
      end
      if (wr_auto) begin
        auto_par <= frame_wdata & 8'hEF;  // see RULE3
      end
      if (wr_misc) begin
        misc <= frame_wdata & 8'hDF;
      end
      if (wr_crank) begin
        cranking <= frame_wdata;  // see RULE2
      end
    end
  end

  // ==========================================================================
  // Status register
  // ==========================================================================
  // While self-test writes are open the flags hold what software wrote and ignore events.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clamp_pos <= 1'b0;
      clamp_neg <= 1'b0;
      overtemp  <= 1'b0;
    end else if (self_test_write_enable) begin
      if (wr_status) begin
        clamp_pos <= frame_wdata[crank_cond_pkg::STAT_CLAMP_POS];  // see RULE18
        clamp_neg <= frame_wdata[crank_cond_pkg::STAT_CLAMP_NEG];
        overtemp  <= frame_wdata[crank_cond_pkg::STAT_OVERTEMP];
      end
    end else begin
      // A new event in the clearing cycle wins over the clear.
      clamp_pos <= (clamp_pos && !(wr_status &&
                    !frame_wdata[crank_cond_pkg::STAT_CLAMP_POS])) ||
                   clamp_pos_hit;  // see RULE12
      clamp_neg <= (clamp_neg && !(wr_status &&
                    !frame_wdata[crank_cond_pkg::STAT_CLAMP_NEG])) ||
                   clamp_neg_hit;  // see RULE13
      overtemp  <= (overtemp && !(wr_status &&
                    !frame_wdata[crank_cond_pkg::STAT_OVERTEMP])) ||
                   kline_overtemp;  // see RULE14
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      peak <= crank_cond_pkg::PEAK_RESET;
    end else if (serial_reset_cmd) begin
      peak <= crank_cond_pkg::PEAK_RESET;  // see RULE16
    end else if (self_test_write_enable) begin
      if (wr_status) begin
        peak <= frame_wdata[crank_cond_pkg::STAT_PEAK_MSB:crank_cond_pkg::STAT_PEAK_LSB];
      end
    end else if (peak_valid) begin
      peak <= peak_code;  // see RULE11
    end
  end

  // ==========================================================================
  // Read answer
  // ==========================================================================
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      frame_rdata <= 8'h00;
      frame_error <= 1'b0;
    end else begin
      frame_error <= 1'b0;
      if (frame_valid) begin
        unique case (1'b1)
          hit(frame_space, frame_addr, crank_cond_pkg::SPACE_CONFIG,
              crank_cond_pkg::ADDR_RUN_STATUS): frame_rdata <= running;
          hit(frame_space, frame_addr, crank_cond_pkg::SPACE_CONFIG,
              crank_cond_pkg::ADDR_AUTO): frame_rdata <= auto_par;
          hit(frame_space, frame_addr, crank_cond_pkg::SPACE_CONFIG,
              crank_cond_pkg::ADDR_MISC_CRANK): frame_rdata <= misc;
          hit(frame_space, frame_addr, crank_cond_pkg::SPACE_CONTROL,
              crank_cond_pkg::ADDR_MISC_CRANK): frame_rdata <= cranking;
          hit(frame_space, frame_addr, crank_cond_pkg::SPACE_STATUS,
              crank_cond_pkg::ADDR_RUN_STATUS): frame_rdata <= status_word;
          default: begin
            frame_rdata <= 8'h00;
            frame_error <= 1'b1;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Threshold selection and conditioner controls
  // ==========================================================================
  threshold_decay u_decay (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .auto_active (misc[crank_cond_pkg::MISC_AUTO]),  // see RULE4
    .zero_cross  (zero_cross),
    .target      (cranking[crank_cond_pkg::THR_MSB:crank_cond_pkg::THR_LSB]),
    .mantissa    (auto_par[crank_cond_pkg::MANT_MSB:crank_cond_pkg::MANT_LSB]),
    .exponent    (auto_par[crank_cond_pkg::EXP_MSB:crank_cond_pkg::EXP_LSB]),
    .threshold   (decay_thr)
  );

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      thresh_sel <= crank_cond_pkg::RUN_RESET[crank_cond_pkg::THR_MSB:crank_cond_pkg::THR_LSB];
      blank_sel  <= crank_cond_pkg::RUN_RESET[crank_cond_pkg::BLANK_MSB:crank_cond_pkg::BLANK_LSB];
    end else if (engine_cranking) begin
      thresh_sel <= decay_thr;  // see RULE4
      blank_sel  <= cranking[crank_cond_pkg::BLANK_MSB:crank_cond_pkg::BLANK_LSB];
    end else begin
      thresh_sel <= running[crank_cond_pkg::THR_MSB:crank_cond_pkg::THR_LSB];  // see RULE1
      blank_sel  <= running[crank_cond_pkg::BLANK_MSB:crank_cond_pkg::BLANK_LSB];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      conditioner_enable    <= 1'b1;
      pulse_low_select      <= 1'b0;
      deglitch_enable       <= 1'b0;
      single_ended_select   <= 1'b0;
      inputs_swapped        <= 1'b0;
      common_ref_disconnect <= 1'b0;
    end else begin
      conditioner_enable    <= !misc[crank_cond_pkg::MISC_DISABLE];  // see RULE5
      pulse_low_select      <= misc[crank_cond_pkg::MISC_LOWPULSE];  // see RULE6
      deglitch_enable       <= misc[crank_cond_pkg::MISC_DEGLITCH];  // see RULE7
      single_ended_select   <= misc[crank_cond_pkg::MISC_SINGLE];    // see RULE8
      inputs_swapped        <= misc[crank_cond_pkg::MISC_SWAP];      // see RULE9
      common_ref_disconnect <= misc[crank_cond_pkg::MISC_REFDIS];    // see RULE10
    end
  end

  // ==========================================================================
  // K-line relay
  // ==========================================================================
  // The line is pulled up outside, so only a low is ever driven.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      kline_out        <= 1'b0;
      kline_oe_n       <= 1'b1;
      kline_rx_to_host <= 1'b1;
    end else begin
      kline_out        <= 1'b0;
      kline_oe_n       <= kline_tx_from_host;  // see RULE15
      kline_rx_to_host <= kline_in;            // see RULE15
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_run_write;
    wr_run |=> running == $past(frame_wdata);
  endproperty
  a_run_write: assert property (p_run_write) else $error("running write lost"); // see RULE1

  property p_crank_write;
    wr_crank |=> cranking == $past(frame_wdata);
  endproperty
  a_crank_write: assert property (p_crank_write) else $error("cranking write lost"); // see RULE2

  property p_no_frame_hold;
    !frame_valid |=> $stable(running) && $stable(misc) && $stable(cranking) && $stable(auto_par);
  endproperty
  a_no_frame_hold: assert property (p_no_frame_hold) else $error("update without frame"); // see RULE19

  property p_disable;
    wr_misc ##1 !wr_misc |=> conditioner_enable == !$past(frame_wdata[6], 2);
  endproperty
  a_disable: assert property (p_disable) else $error("disable bit ignored"); // see RULE5

  property p_auto_max;
    (misc[7] && engine_cranking && zero_cross) ##1 engine_cranking |=> thresh_sel == 4'hF;
  endproperty
  a_auto_max: assert property (p_auto_max) else $error("auto max missing"); // see RULE17

  property p_peak_capture;
    peak_valid && !serial_reset_cmd && !self_test_write_enable |=> peak == $past(peak_code);
  endproperty
  a_peak_capture: assert property (p_peak_capture) else $error("peak not captured"); // see RULE11

  property p_peak_hold;
    !peak_valid && !serial_reset_cmd && !wr_status |=> $stable(peak);
  endproperty
  a_peak_hold: assert property (p_peak_hold) else $error("peak changed"); // see RULE16

  property p_clamp_pos;
    clamp_pos_hit && !self_test_write_enable |=> clamp_pos;
  endproperty
  a_clamp_pos: assert property (p_clamp_pos) else $error("pos clamp lost"); // see RULE12

  property p_clamp_neg;
    clamp_neg_hit && !self_test_write_enable |=> clamp_neg;
  endproperty
  a_clamp_neg: assert property (p_clamp_neg) else $error("neg clamp lost"); // see RULE13

  property p_overtemp;
    kline_overtemp && !self_test_write_enable |=> overtemp ##1 (overtemp || $past(wr_status));
  endproperty
  a_overtemp: assert property (p_overtemp) else $error("overtemp lost"); // see RULE14

  property p_kline;
    !kline_out && kline_oe_n == $past(kline_tx_from_host) && kline_rx_to_host == $past(kline_in);
  endproperty
  a_kline: assert property (p_kline) else $error("kline relay wrong"); // see RULE15

  c_auto_decay:  cover property (misc[7] && engine_cranking && zero_cross);
  c_self_test:   cover property (self_test_write_enable && wr_status);
  c_serial_rst:  cover property (peak != 4'h0 ##1 serial_reset_cmd);
  c_clear_flag:  cover property (clamp_pos && wr_status && !frame_wdata[2]);

endmodule

/* verification/kline_bus_model.sv */
// Purpose: K-line wire with its pull-up and one remote node on the far side.
// Assumes: The design only ever pulls the line low, as an open-drain driver.
// Notes:   With no node pulling low the line sits at the pull-up level.

`timescale 1ns/10ps

module kline_bus_model (
  input  wire logic kline_oe_n,
  input  wire logic remote_low,
  output logic      kline_level
);
  // ==========================================================================
  // Wired-and line
  // ==========================================================================
  // A released line reads the pull-up level, never the last driven value.
  assign kline_level = !(!kline_oe_n || remote_low);
endmodule

/* verification/test_crank_sensor_conditioner_regs.sv */
// Purpose: Self-checking bench for the crank sensor conditioner register bank.
// Assumes: Frames arrive as decoded one-cycle pulses, one per task call.
// Notes:   Shadow registers predict the configuration reads and pins; reset, status and cranking checks use fixed values; K-line checks follow the loop index.

`timescale 1ns/10ps

module test_crank_sensor_conditioner_regs;
  localparam crank_cond_pkg::reg_space_t CFG = crank_cond_pkg::SPACE_CONFIG;
  localparam crank_cond_pkg::reg_space_t CTL = crank_cond_pkg::SPACE_CONTROL;
  localparam crank_cond_pkg::reg_space_t STS = crank_cond_pkg::SPACE_STATUS;
  logic                       clk_sys, rst, frame_valid, frame_write, frame_error;
  crank_cond_pkg::reg_space_t frame_space;
  logic [3:0]                 frame_addr, peak_code, thresh_sel, blank_sel;
  logic [7:0]                 frame_wdata, frame_rdata, m_run, m_auto, m_misc, m_crank;
  logic                       serial_reset_cmd, self_test_write_enable, engine_cranking;
  logic                       zero_cross, peak_valid, clamp_pos_hit, clamp_neg_hit;
  logic                       kline_overtemp, kline_tx_from_host, kline_in, kline_out;
  logic                       kline_oe_n, kline_rx_to_host, conditioner_enable, remote_low;
  logic                       pulse_low_select, deglitch_enable, single_ended_select;
  logic                       inputs_swapped, common_ref_disconnect;
  int                         n_mismatch, checked;

  crank_sensor_conditioner_regs i_crank_sensor_conditioner_regs (
    .clk_sys(clk_sys), .rst(rst), .frame_valid(frame_valid), .frame_write(frame_write),
    .frame_space(frame_space), .frame_addr(frame_addr), .frame_wdata(frame_wdata),
    .frame_rdata(frame_rdata), .frame_error(frame_error),
    .serial_reset_cmd(serial_reset_cmd), .self_test_write_enable(self_test_write_enable),
    .engine_cranking(engine_cranking), .zero_cross(zero_cross), .peak_valid(peak_valid),
    .peak_code(peak_code), .clamp_pos_hit(clamp_pos_hit), .clamp_neg_hit(clamp_neg_hit),
    .kline_overtemp(kline_overtemp), .kline_tx_from_host(kline_tx_from_host),
    .kline_in(kline_in), .kline_out(kline_out), .kline_oe_n(kline_oe_n),
    .kline_rx_to_host(kline_rx_to_host), .thresh_sel(thresh_sel), .blank_sel(blank_sel),
    .conditioner_enable(conditioner_enable), .pulse_low_select(pulse_low_select),
    .deglitch_enable(deglitch_enable), .single_ended_select(single_ended_select),
    .inputs_swapped(inputs_swapped), .common_ref_disconnect(common_ref_disconnect));

  kline_bus_model i_kline_bus_model (
    .kline_oe_n(kline_oe_n), .remote_low(remote_low), .kline_level(kline_in));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic chk_rd(input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t read exp %h got %h", $time, exp, got);
    end
  endtask

  task automatic chk_pin(input logic [3:0] exp, input logic [3:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t pin exp %h got %h", $time, exp, got);
    end
  endtask

  task automatic edges(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic frame(input logic w, input crank_cond_pkg::reg_space_t sp,
                       input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    frame_valid <= 1'b1;
    frame_write <= w;
    frame_space <= sp;
    frame_addr <= a;
    frame_wdata <= d;
    @(posedge clk_sys);
    frame_valid <= 1'b0;
    #1;
  endtask

  task automatic rd(input crank_cond_pkg::reg_space_t sp, input logic [3:0] a,
                    input logic [7:0] exp);
    frame(1'b0, sp, a, 8'h00);
    chk_rd(exp, frame_rdata);
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================================
  // Clock, watchdog and tests
  // ==========================================================================
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (5000) @(posedge clk_sys);
    n_mismatch++;
    close_out();
  end

  initial begin
    {rst, kline_tx_from_host} = 2'h3;
    {frame_valid, frame_write, serial_reset_cmd, self_test_write_enable} = 4'h0;
    {engine_cranking, zero_cross, peak_valid, clamp_pos_hit, clamp_neg_hit} = 5'h00;
    {kline_overtemp, remote_low, frame_addr, peak_code, frame_wdata} = 18'h00000;
    frame_space = CFG;
    void'($urandom(15));
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    rd(CFG, 4'hB, 8'h53);
    rd(CFG, 4'hC, 8'h21);
    rd(CFG, 4'hD, 8'h00);
    rd(CTL, 4'hD, 8'h00);
    rd(STS, 4'hB, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      {m_run, m_auto, m_misc, m_crank} = 32'($urandom);
      frame(1'b1, CFG, 4'hB, m_run);
      frame(1'b1, CFG, 4'hC, m_auto);
      frame(1'b1, CFG, 4'hD, m_misc);
      frame(1'b1, CTL, 4'hD, m_crank);
      frame(1'b1, CTL, 4'hB, 8'hFF);
      chk_pin(4'h1, {3'h0, frame_error});
      rd(CFG, 4'hB, m_run);
      rd(CFG, 4'hC, m_auto & 8'hEF);
      rd(CFG, 4'hD, m_misc & 8'hDF);
      rd(CTL, 4'hD, m_crank);
      chk_pin(m_run[7:4], thresh_sel);
      chk_pin(m_run[3:0], blank_sel);
      chk_pin(m_misc[4:1], {pulse_low_select, deglitch_enable, single_ended_select,
                            inputs_swapped});
      chk_pin({2'h0, ~m_misc[6], m_misc[0]},
              {kline_out, 1'b0, conditioner_enable, common_ref_disconnect});
    end
    $display("test config done");
    @(posedge clk_sys);
    {clamp_pos_hit, clamp_neg_hit, kline_overtemp, peak_valid, peak_code} <= 8'hFA;
    @(posedge clk_sys);
    {clamp_pos_hit, clamp_neg_hit, kline_overtemp, peak_valid} <= 4'h0;
    rd(STS, 4'hB, 8'hA7);
    frame(1'b1, STS, 4'hB, 8'h0B);
    rd(STS, 4'hB, 8'hA3);
    frame(1'b1, STS, 4'hB, 8'h00);
    rd(STS, 4'hB, 8'hA0);
    @(posedge clk_sys);
    serial_reset_cmd <= 1'b1;
    @(posedge clk_sys);
    serial_reset_cmd <= 1'b0;
    rd(STS, 4'hB, 8'h00);
    @(posedge clk_sys);
    self_test_write_enable <= 1'b1;
    frame(1'b1, STS, 4'hB, 8'h5E);
    rd(STS, 4'hB, 8'h56);
    @(posedge clk_sys);
    self_test_write_enable <= 1'b0;
    frame(1'b1, STS, 4'hB, 8'h00);
    rd(STS, 4'hB, 8'h50);
    $display("test status done");
    @(posedge clk_sys);
    engine_cranking <= 1'b1;
    frame(1'b1, CFG, 4'hD, 8'h00);
    frame(1'b1, CFG, 4'hC, 8'h21);
    frame(1'b1, CTL, 4'hD, 8'hE3);
    edges(2);
    chk_pin(4'hE, thresh_sel);
    chk_pin(blank_sel, 4'h3);
    frame(1'b1, CFG, 4'hD, 8'h80);
    @(posedge clk_sys);
    zero_cross <= 1'b1;
    @(posedge clk_sys);
    zero_cross <= 1'b0;
    edges(2);
    chk_pin(4'hF, thresh_sel);
    edges(31);
    chk_pin(4'hF, thresh_sel);
    edges(2);
    chk_pin(4'hE, thresh_sel);
    $display("test cranking done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      kline_tx_from_host <= i[0];
      remote_low <= i[1];
      edges(3);
      chk_pin({3'h0, i[0]}, {3'h0, kline_oe_n});
      chk_pin({3'h0, i[0] & ~i[1]}, {3'h0, kline_rx_to_host});
    end
    $display("test kline done");
    close_out();
  end
endmodule
